/* File: rtl/bus_qual_pkg.sv */
// Purpose: shared constants for the bus queue event qualifier
// Assumes: 32-bit Avalon-MM register window, word aligned
// Notes: byte offsets below are byte addresses on the bus
package bus_qual_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [3:0] SEL_REG_ADDR = 4'h0;   // bus_event_select_reg0
  localparam logic [3:0] CTRL_REG_ADDR = 4'h4;  // counter enables
  localparam logic [3:0] CNT0_REG_ADDR = 4'h8;  // counter 0
  localparam logic [3:0] CNT1_REG_ADDR = 4'hC;  // counter 1

  // ==========================================================
  // event select register layout
  localparam int CODE_LSB = 25;
  localparam int CODE_MSB = 31;
  localparam int MASK_LSB = 9;
  localparam int MASK_MSB = 24;
  localparam int SEL_EN_BIT = 0;
  localparam logic [6:0] ALLOC_EVENT_CODE = 7'h03;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] SEL_WMASK = 32'hFFFF_FE01;

  // ==========================================================
  // event mask field positions (within the 16-bit mask)
  localparam int RT_LSB = 0;
  localparam int RT_MSB = 4;
  localparam int ALL_READ_BIT = 5;
  localparam int ALL_WRITE_BIT = 6;
  localparam int MEM_LSB = 7;
  localparam int MEM_MSB = 8;
  localparam int AGENT_LSB = 13;
  localparam int AGENT_MSB = 14;
  localparam int PREFETCH_BIT = 15;
  localparam logic [4:0] RT_DEFAULT = 5'h01;

  // ==========================================================
  // control register layout
  localparam int CNT0_EN_BIT = 0;
  localparam int CNT1_EN_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // any selected bit of a two-bit mask field against a two-bit attribute
  function automatic logic field_hit(input logic [1:0] sel, input logic [1:0] attr);
    field_hit = |(sel & attr);
  endfunction

endpackage

/* File: rtl/alloc_match.sv */
// Purpose: combinational mask match for one in_order_bus_queue allocation
// Assumes: inputs stable in the cycle alloc_valid_i is high
// Notes: sector or chunk size plays no part in the match
`timescale 1ns/1ps
module alloc_match (
  input wire logic alloc_valid_i,
  input wire logic [15:0] mask_i,
  input wire logic [4:0] req_type_i,
  input wire logic is_read_i,
  input wire logic is_write_i,
  input wire logic mem_uc_i,
  input wire logic mem_wc_i,
  input wire logic own_agent_i,
  input wire logic prefetch_i,
  output logic rt_hit_o,
  output logic mem_hit_o,
  output logic agent_hit_o,
  output logic match_o
);
  import bus_qual_pkg::*;

  logic read_ok;
  logic rd_hit;
  logic wr_hit;

  // ==========================================================
  // field terms
  // prefetch reads only pass the type and all-read terms when the prefetch bit is set; others ignore it
  always_comb begin
    read_ok = is_read_i && (!prefetch_i || mask_i[PREFETCH_BIT]);
    // whole five-bit field compared, value 00001 being the default type
    rt_hit_o = alloc_valid_i && (req_type_i == mask_i[RT_MSB:RT_LSB]) &&
               (!is_read_i || read_ok);
    rd_hit = alloc_valid_i && mask_i[ALL_READ_BIT] && read_ok;
    wr_hit = alloc_valid_i && mask_i[ALL_WRITE_BIT] && is_write_i;
    mem_hit_o = alloc_valid_i &&
                field_hit(mask_i[MEM_MSB:MEM_LSB], {mem_wc_i, mem_uc_i});
    agent_hit_o = field_hit(mask_i[AGENT_MSB:AGENT_LSB],
                            {!own_agent_i, own_agent_i});
    match_o = (rt_hit_o || rd_hit || wr_hit || mem_hit_o) && agent_hit_o;
  end

endmodule

/* File: rtl/cache_ref_classify.sv */
// Purpose: read or write classification of a bus_unit_cache_ref_event access
// Assumes: status inputs reflect the access as it stands when observed
// Notes: registered, one cycle behind the access strobe
`timescale 1ns/1ps
module cache_ref_classify (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic valid_i,
  input wire logic load_i,
  input wire logic request_for_ownership_i,
  input wire logic writeback_i,
  input wire logic hit_i,
  output logic valid_o,
  output logic read_o,
  output logic write_o,
  output logic hit_o
);

  logic valid_q, valid_d, read_q, read_d, write_q, write_d, hit_q, hit_d;

  // ==========================================================
  // classification; a former prefetch is taken as it is now, no history kept
  always_comb begin
    valid_d = valid_i;
    read_d = valid_i && (load_i || request_for_ownership_i);
    write_d = valid_i && writeback_i && !(load_i || request_for_ownership_i);
    hit_d = valid_i && hit_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      valid_q <= 1'b0;
      read_q <= 1'b0;
      write_q <= 1'b0;
      hit_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
      read_q <= read_d;
      write_q <= write_d;
      hit_q <= hit_d;
    end
  end

  assign valid_o = valid_q;
  assign read_o = read_q;
  assign write_o = write_q;
  assign hit_o = hit_q;

endmodule

/* File: rtl/bus_queue_event_qualifier.sv */
// Purpose: qualifies in_order_bus_queue allocations against a programmed mask
// Assumes: all event inputs come from logic on mclk_i
// Notes: registers on Avalon-MM, one wait cycle per access
`timescale 1ns/1ps
module bus_queue_event_qualifier #(
  parameter int CNT_W = 32
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // queue allocation strobe
  input wire logic alloc_valid_i,
  input wire logic [4:0] alloc_req_type_i,
  input wire logic alloc_is_read_i,
  input wire logic alloc_is_write_i,
  input wire logic alloc_mem_uc_i,
  input wire logic alloc_mem_wc_i,
  input wire logic alloc_own_i,
  input wire logic alloc_prefetch_i,
  input wire logic alloc_sector_i,
  // cache reference strobe
  input wire logic cref_valid_i,
  input wire logic cref_load_i,
  input wire logic cref_request_for_ownership_i,
  input wire logic cref_writeback_i,
  input wire logic cref_hit_i,
  // results
  output logic alloc_count_o,
  output logic cref_valid_o,
  output logic cref_read_o,
  output logic cref_write_o,
  output logic cref_hit_o
);
  import bus_qual_pkg::*;

  // ==========================================================
  // state
  logic [31:0] sel_q, sel_d;
  logic [1:0] ctrl_q, ctrl_d;
  logic [CNT_W-1:0] cnt0_q, cnt0_d, cnt1_q, cnt1_d;
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic count_q, count_d;
  logic [15:0] mask;
  logic sel_ok;
  logic match;
  logic rt_hit, mem_hit, agent_hit;
  logic wr_acc;
  logic wr_sel, wr_ctrl, wr_cnt0, wr_cnt1;

  // merge byte lanes of a write into an old word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    lane_merge = r;
  endfunction

  // ==========================================================
  // decode of the select register
  assign mask = sel_q[MASK_MSB:MASK_LSB];
  assign sel_ok = sel_q[SEL_EN_BIT] && (sel_q[CODE_MSB:CODE_LSB] == ALLOC_EVENT_CODE);

  // match terms for the current allocation
  alloc_match u_match (
    .alloc_valid_i(alloc_valid_i),
    .mask_i(mask),
    .req_type_i(alloc_req_type_i),
    .is_read_i(alloc_is_read_i),
    .is_write_i(alloc_is_write_i),
    .mem_uc_i(alloc_mem_uc_i),
    .mem_wc_i(alloc_mem_wc_i),
    .own_agent_i(alloc_own_i),
    .prefetch_i(alloc_prefetch_i),
    .rt_hit_o(rt_hit),
    .mem_hit_o(mem_hit),
    .agent_hit_o(agent_hit),
    .match_o(match)
  );

  // cache reference classifier, registered inside
  cache_ref_classify u_cref (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .valid_i(cref_valid_i),
    .load_i(cref_load_i),
    .request_for_ownership_i(cref_request_for_ownership_i),
    .writeback_i(cref_writeback_i),
    .hit_i(cref_hit_i),
    .valid_o(cref_valid_o),
    .read_o(cref_read_o),
    .write_o(cref_write_o),
    .hit_o(cref_hit_o)
  );

  // ==========================================================
  // bus slave: waitrequest high on the first request cycle, low on the second
  // one fixed wait keeps read data registered without a decode stall
  // limitation: every access costs two cycles, reads and writes alike
  assign wr_acc = avs_write_i && !wait_q;
  assign wr_sel = wr_acc && (avs_address_i == SEL_REG_ADDR);
  assign wr_ctrl = wr_acc && (avs_address_i == CTRL_REG_ADDR);
  assign wr_cnt0 = wr_acc && (avs_address_i == CNT0_REG_ADDR);
  assign wr_cnt1 = wr_acc && (avs_address_i == CNT1_REG_ADDR);

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = 32'h0000_0000; // unmapped reads return zero
      unique case (avs_address_i)
        SEL_REG_ADDR: rdata_d = sel_q;
        CTRL_REG_ADDR: rdata_d = {30'h0, ctrl_q};
        CNT0_REG_ADDR: rdata_d = 32'(cnt0_q);
        CNT1_REG_ADDR: rdata_d = 32'(cnt1_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // configuration registers; reserved select bits read as zero
  // ctrl only has lane 0; other lanes of a ctrl write are dropped
  always_comb begin
    sel_d = sel_q;
    ctrl_d = ctrl_q;
    if (wr_sel) begin
      sel_d = lane_merge(sel_q, avs_writedata_i, avs_byteenable_i) & SEL_WMASK;
    end
    if (wr_ctrl && avs_byteenable_i[0]) begin
      ctrl_d = avs_writedata_i[CNT1_EN_BIT:CNT0_EN_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sel_q <= SEL_RESET;
      ctrl_q <= CTRL_RESET;
    end else begin
      sel_q <= sel_d;
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================
  // qualified count pulse, one per matching allocation of any size
  // a retried request arrives as a fresh allocation and is counted again
  // sector and chunk entries share one pulse, size never reaches the match
  always_comb begin
    count_d = alloc_valid_i && match && sel_ok;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      count_q <= 1'b0;
    end else begin
      count_q <= count_d;
    end
  end

  // ==========================================================
  // the two counters tied to select register zero; a software write wins
  // over an increment in the same cycle, so a preset value is never skewed
  always_comb begin
    cnt0_d = cnt0_q;
    cnt1_d = cnt1_q;
    if (wr_cnt0) begin
      cnt0_d = CNT_W'(lane_merge(32'(cnt0_q), avs_writedata_i, avs_byteenable_i));
    end else if (count_q && ctrl_q[CNT0_EN_BIT]) begin
      cnt0_d = cnt0_q + CNT_W'(1);
    end
    if (wr_cnt1) begin
      cnt1_d = CNT_W'(lane_merge(32'(cnt1_q), avs_writedata_i, avs_byteenable_i));
    end else if (count_q && ctrl_q[CNT1_EN_BIT]) begin
      cnt1_d = cnt1_q + CNT_W'(1);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt0_q <= '0;
      cnt1_q <= '0;
    end else begin
      cnt0_q <= cnt0_d;
      cnt1_q <= cnt1_d;
    end
  end

  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = wait_q;
  assign alloc_count_o = count_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  count_cause_a: assert property (count_q |-> $past(sel_ok) && $past(agent_hit))
    else $error("count pulse without select or agent match");
  alloc_count_a: assert property (alloc_valid_i && match && sel_ok |=> count_q)
    else $error("matching allocation not counted");
  off_silent_a: assert property (!sel_ok |=> !count_q)
    else $error("count pulse while event not selected");
  // the pulse for the first of two strobes is one cycle old when the second pulse is seen
  retry_twice_a: assert property ((alloc_valid_i && match && sel_ok) [*2] |=>
    count_q && $past(count_q))
    else $error("back to back allocations not both counted");
  cnt_step_a: assert property (count_q && ctrl_q[CNT0_EN_BIT] && !wr_cnt0 |=>
    cnt0_q == $past(cnt0_q) + CNT_W'(1))
    else $error("counter 0 did not step by one");
  rt_field_a: assert property (alloc_valid_i && sel_ok && agent_hit && !alloc_is_read_i &&
    alloc_req_type_i == mask[RT_MSB:RT_LSB] |=> count_q)
    else $error("request type match not counted");
  mem_type_a: assert property (alloc_valid_i && sel_ok && agent_hit && alloc_mem_uc_i &&
    mask[MEM_LSB] |=> count_q)
    else $error("memory type match not counted");
  agent_gate_a: assert property (alloc_valid_i && !agent_hit |=> !count_q)
    else $error("count without source agent match");
  pf_read_a: assert property (alloc_valid_i && alloc_is_read_i && !alloc_is_write_i &&
    alloc_prefetch_i && !mask[PREFETCH_BIT] && !mem_hit |=> !count_q)
    else $error("prefetch read counted with prefetch bit clear");
  all_read_a: assert property (alloc_valid_i && sel_ok && agent_hit && alloc_is_read_i &&
    !alloc_prefetch_i && mask[ALL_READ_BIT] |=> count_q)
    else $error("all reads bit did not count a read");
  code_pos_a: assert property (count_q |-> $past(sel_q[CODE_MSB:CODE_LSB]) == ALLOC_EVENT_CODE)
    else $error("count with wrong event code");
  cref_rd_a: assert property (cref_valid_i &&
    (cref_load_i || cref_request_for_ownership_i) |=> cref_read_o)
    else $error("load or ownership request not a read");
  cref_now_a: assert property (cref_valid_i |=> cref_hit_o == $past(cref_hit_i))
    else $error("cache reference hit status not current");
  bus_wait_a: assert property ((avs_read_i || avs_write_i) && wait_q |=> !avs_waitrequest_o)
    else $error("waitrequest not released after one cycle");
  ack_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  sel_rsvd_a: assert property ((sel_q & ~SEL_WMASK) == 32'h0000_0000)
    else $error("reserved select bits not zero");

  // ==========================================================
  // extra count, counter and cache reference checks
  // a pulse with no strobe would overcount idle bus cycles
  no_alloc_a: assert property (!alloc_valid_i |=> !count_q)
    else $error("count pulse without an allocation");
  wr_all_a: assert property (alloc_valid_i && sel_ok && agent_hit &&
    alloc_is_write_i && mask[ALL_WRITE_BIT] |=> count_q)
    else $error("all writes bit did not count a write");
  cnt1_step_a: assert property (count_q && ctrl_q[CNT1_EN_BIT] && !wr_cnt1 |=>
    cnt1_q == $past(cnt1_q) + CNT_W'(1))
    else $error("counter 1 did not step by one");
  cnt_hold_a: assert property (!count_q && !wr_cnt0 |=> $stable(cnt0_q))
    else $error("counter 0 moved without a pulse or write");
  cref_wr_a: assert property (cref_valid_i && cref_writeback_i && !cref_load_i &&
    !cref_request_for_ownership_i |=> cref_write_o)
    else $error("writeback not classified as a write");
  cref_idle_a: assert property (!cref_valid_i |=> !cref_read_o && !cref_write_o)
    else $error("cache reference result without a strobe");

  // main scenarios: back-to-back counts, default type, reads, sectors, writes

  alloc_hit_c: cover property (count_q ##1 count_q);
  rt_default_c: cover property (count_q && mask[RT_MSB:RT_LSB] == RT_DEFAULT);
  cref_read_c: cover property (cref_read_o && cref_hit_o);
  sector_c: cover property (alloc_valid_i && alloc_sector_i && match && sel_ok);
  all_write_c: cover property (count_q && mask[ALL_WRITE_BIT]);

endmodule

/* File: verif/testbench.sv */
// Purpose: self-checking bench for bus_queue_event_qualifier
// Assumes: one wait cycle per register access, result pulses one cycle after strobes
// Notes: random traffic from a bench lfsr seeded with 60, corner masks first
`timescale 1ns/1ps
module testbench;
  import bus_qual_pkg::*;
  // ==========================================================
  // design ports
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [3:0] avs_byteenable_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic alloc_valid_i = 1'b0;
  logic [4:0] alloc_req_type_i = 5'h00;
  logic alloc_is_read_i = 1'b0;
  logic alloc_is_write_i = 1'b0;
  logic alloc_mem_uc_i = 1'b0;
  logic alloc_mem_wc_i = 1'b0;
  logic alloc_own_i = 1'b0;
  logic alloc_prefetch_i = 1'b0;
  logic alloc_sector_i = 1'b0;
  logic cref_valid_i = 1'b0;
  logic cref_load_i = 1'b0;
  logic cref_request_for_ownership_i = 1'b0;
  logic cref_writeback_i = 1'b0;
  logic cref_hit_i = 1'b0;
  logic alloc_count_o;
  logic cref_valid_o;
  logic cref_read_o;
  logic cref_write_o;
  logic cref_hit_o;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [15:0] seed = 16'h003C;
  // corner masks: default type/own, all-read/own, all-write/other, memory types/both agents
  localparam logic [15:0] MASK_TBL [4] = '{16'h2001, 16'h2020, 16'h4040, 16'hE180};

  bus_queue_event_qualifier #(.CNT_W(32)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .alloc_valid_i(alloc_valid_i),
    .alloc_req_type_i(alloc_req_type_i), .alloc_is_read_i(alloc_is_read_i),
    .alloc_is_write_i(alloc_is_write_i), .alloc_mem_uc_i(alloc_mem_uc_i),
    .alloc_mem_wc_i(alloc_mem_wc_i), .alloc_own_i(alloc_own_i),
    .alloc_prefetch_i(alloc_prefetch_i), .alloc_sector_i(alloc_sector_i),
    .cref_valid_i(cref_valid_i), .cref_load_i(cref_load_i),
    .cref_request_for_ownership_i(cref_request_for_ownership_i),
    .cref_writeback_i(cref_writeback_i), .cref_hit_i(cref_hit_i),
    .alloc_count_o(alloc_count_o), .cref_valid_o(cref_valid_o), .cref_read_o(cref_read_o),
    .cref_write_o(cref_write_o), .cref_hit_o(cref_hit_o)
  );

  // ==========================================================
  // clock, 25 ns period
  initial begin
    forever begin
      #12.5 mclk_i = ~mclk_i;
    end
  end

  // ==========================================================
  // helpers and expectations
  function automatic logic [15:0] draw();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction

  // a prefetching read drops its type and all-read terms unless bit 15 lets it in
  function automatic logic alloc_exp(input logic [31:0] sel, input logic [4:0] rt,
                                     input logic rd, input logic uc, input logic wc,
                                     input logic own, input logic pf);
    logic [15:0] m;
    logic gate;
    logic term;
    m = sel[MASK_MSB:MASK_LSB];
    gate = !(rd && pf && !m[PREFETCH_BIT]);
    term = (gate && ((rt == m[RT_MSB:RT_LSB]) || (m[ALL_READ_BIT] && rd)))
      || (m[ALL_WRITE_BIT] && !rd) || (m[MEM_LSB] && uc) || (m[MEM_MSB] && wc);
    alloc_exp = sel[SEL_EN_BIT] && (sel[CODE_MSB:CODE_LSB] == ALLOC_EVENT_CODE) && term
      && ((m[AGENT_LSB] && own) || (m[AGENT_MSB] && !own));
  endfunction

  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: pulse got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: word got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until the edge that sees waitrequest low; data taken at that edge
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [3:0] be,
                          input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_byteenable_i <= be;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    // only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, 4'hF, d, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b0, a, 4'hF, 32'h0, q);
    check_word(q, exp);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, well beyond the ~1800 cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk_i);
    n_mismatch++;
    $display("ERROR at %0t: timeout", $time);
    end_of_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] sel;
    logic [31:0] q;
    logic [15:0] m;
    logic [15:0] r;
    logic [15:0] r2;
    logic [1:0] ctrl;
    logic [3:0] exp_c;
    logic exp_a;
    logic v;
    logic [4:0] rt;
    logic uc;
    logic wc;
    int n_exp;
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    check_bit(avs_waitrequest_o, 1'b1);
    check_bit(alloc_count_o, 1'b0);
    rd_chk(SEL_REG_ADDR, SEL_RESET);
    rd_chk(CTRL_REG_ADDR, {30'h0, CTRL_RESET});
    rd_chk(CNT0_REG_ADDR, 32'h0);
    rd_chk(CNT1_REG_ADDR, 32'h0);
    wr_reg(SEL_REG_ADDR, 32'hFFFF_FFFF);
    rd_chk(SEL_REG_ADDR, SEL_WMASK);
    bus_xfer(1'b1, 4'h2, 4'hF, 32'hFFFF_FFFF, q);
    rd_chk(4'h2, 32'h0);
    rd_chk(SEL_REG_ADDR, SEL_WMASK);
    wr_reg(SEL_REG_ADDR, 32'h0);
    bus_xfer(1'b1, SEL_REG_ADDR, 4'h1, 32'hFFFF_FFFF, q);
    rd_chk(SEL_REG_ADDR, 32'h0000_0001);
    // phases 4 and 5 random masks, 6 another event code, 7 select disabled
    for (int ph = 0; ph < 8; ph++) begin
      r = draw();
      r2 = draw();
      m = (ph < 4) ? MASK_TBL[ph] : {r[15:0] ^ r2[15:0]};
      sel = {((ph == 6) ? 7'h0C : ALLOC_EVENT_CODE), m, 8'h00, (ph != 7)};
      ctrl = (ph == 2) ? 2'h1 : 2'h3;
      wr_reg(SEL_REG_ADDR, sel);
      wr_reg(CTRL_REG_ADDR, {30'h0, ctrl});
      wr_reg(CNT0_REG_ADDR, 32'h0);
      wr_reg(CNT1_REG_ADDR, 32'h0);
      n_exp = 0;
      exp_a = 1'b0;
      exp_c = 4'h0;
      // mostly back-to-back strobes; equal repeats stand for retried requests
      for (int i = 0; i <= 200; i++) begin
        @(posedge mclk_i);
        r = draw();
        r2 = draw();
        v = (i < 200) && (r[0] || r[1]);
        rt = r[2] ? m[4:0] : r[7:3];
        uc = r[9];
        wc = r[10] && !r[9];
        alloc_valid_i <= v;
        alloc_req_type_i <= rt;
        alloc_is_read_i <= r[8];
        alloc_is_write_i <= !r[8];
        alloc_mem_uc_i <= uc;
        alloc_mem_wc_i <= wc;
        alloc_own_i <= r[11];
        alloc_prefetch_i <= r[12];
        alloc_sector_i <= r[13];
        cref_valid_i <= (i < 200) && r2[0];
        cref_load_i <= r2[1];
        cref_request_for_ownership_i <= r2[2];
        cref_writeback_i <= r2[3];
        cref_hit_i <= r2[4];
        #1;
        check_bit(alloc_count_o, exp_a);
        check_bit(cref_valid_o, exp_c[3]);
        if (exp_c[3]) begin
          check_bit(cref_read_o, exp_c[2]);
          check_bit(cref_write_o, exp_c[1]);
          check_bit(cref_hit_o, exp_c[0]);
        end
        exp_a = v && alloc_exp(sel, rt, r[8], uc, wc, r[11], r[12]);
        n_exp += int'(exp_a);
        exp_c = {(i < 200) && r2[0], r2[1] || r2[2], r2[3] && !(r2[1] || r2[2]), r2[4]};
      end
      repeat (2) @(posedge mclk_i);
      rd_chk(CNT0_REG_ADDR, ctrl[0] ? 32'(n_exp) : 32'h0);
      rd_chk(CNT1_REG_ADDR, ctrl[1] ? 32'(n_exp) : 32'h0);
    end
    end_of_test;
  end
endmodule
